// ### hw/asrf_fifo.v
/*
  Parameterised synchronous FIFO with valid/ready on both sides.
  Assumes a single clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
module asrf_fifo #(
  parameter WIDTH = 29,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // Fill side
  input wire in_valid_in,
  input wire [WIDTH-1:0] in_data_in,
  output wire in_ready_out,
  // Drain side
  output wire out_valid_out,
  output wire [WIDTH-1:0] out_data_out,
  input wire out_ready_in
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  assign in_ready_out = (count != DEPTH[AW:0]);
  assign out_valid_out = (count != {(AW+1){1'b0}});
  assign out_data_out = mem[rd_ptr];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  always @(posedge clk_in)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_in;
    end
  end
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop && !push)
      begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // asrf_fifo

// ### hw/asrf_framer.v
/*
  Serial result framer: formats conversion results into 32-bit frames, shifts them out
  under chip select and serial clock, takes the next channel address, and picks the
  conversion clock source from the rejection-select pin.
  Assumes the converter core hands results with a valid/ready strobe and that all pins
  come from outside the clk_in domain.
*/
// What this block does
// - Each result goes out as a 32-bit frame, most significant bit first.
// - Bit 31 is conversion-done flag, high while converting, low when done.
// - Bit 30 is a filler bit, always zero.
// - Bit 29 is the sign, high for positive or zero input.
// - Over-range sends bits 29 and 28 high; under-range sends both low.
// - Bits 28 to 6 carry the 23-bit result, MSB at bit 28.
// - Bits 5 to 1 echo the conversion's address, single-ended select first.
// - Bit 0 makes the count of ones in the frame even.
// - Address shifted in during readout selects and reports the next conversion.
// - Chip select high keeps SDO released and SCK ignored.
// - With chip select low the done flag shows and falls at once on completion.
// - Bit 31 shows first; later bits shift on falling edges; bit 0 after 31st.
// - The 32nd falling edge starts a conversion and drives SDO high.
// - Results above full scale clamp to +FS; results below -FS clamp to -FS minus one LSB.
// - Minus one LSB and negative full scale code as specified.
// - Rejection-select low gives 60 Hz, high gives 50 Hz, with internal oscillator.
// - A clock of 2560 Hz or more on rejection select becomes conversion clock.
// - Without that clock the internal oscillator runs again.
// - Clock-source changes never corrupt the serial data stream.
// - Frame bits leave on SCK falling edges; address bits are taken on rising.
// - Sleep lasts until the first SCK rising edge with chip select low.
// - Chip select rising in data state aborts and starts conversion; partial address dropped.
// - SCK level at chip-select fall picks internal or external SCK; reset always gives external.
`timescale 1ns/1ns
`include "asrf_map.vh"
module asrf_framer #(
  parameter FIFO_DEPTH = 8,
  parameter EXT_TIMEOUT = `ASRF_EXT_TIMEOUT
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // Results from the converter core
  input wire result_valid_in,
  input wire [`ASRF_IN_BITS-1:0] result_in,
  output wire result_ready_out,
  // Conversion control toward the core
  output reg conv_start_out,
  output reg [`ASRF_ADDR_BITS-1:0] conv_addr_out,
  output reg converting_out,
  // Clock source selection
  input wire rejection_clock_select_in,
  output reg ext_clock_mode_out,
  output reg osc_enable_out,
  output reg reject_50hz_out,
  // Serial pins
  input wire cs_n_in,
  input wire sck_in,
  output reg sck_out,
  output wire sck_oe_out,
  input wire sdi_in,
  output reg sdo_out,
  output wire sdo_oe_out
);
  // ==========================================================
  // Pin synchronisers
  reg [1:0] cs_s;
  reg [1:0] sck_s;
  reg [1:0] sdi_s;
  reg [1:0] fo_s;
  reg cs_d;
  reg sck_d;
  reg fo_d;
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      cs_s <= 2'h3;
      sck_s <= 2'h0;
      sdi_s <= 2'h0;
      fo_s <= 2'h0;
      cs_d <= 1'b1;
      sck_d <= 1'b0;
      fo_d <= 1'b0;
    end
    else
    begin
      cs_s <= {cs_s[0], cs_n_in};
      sck_s <= {sck_s[0], sck_in};
      sdi_s <= {sdi_s[0], sdi_in};
      fo_s <= {fo_s[0], rejection_clock_select_in};
      cs_d <= cs_s[1];
      sck_d <= sck_s[1];
      fo_d <= fo_s[1];
    end
  end
  wire cs_low = ~cs_s[1];
  wire cs_fall = cs_d & ~cs_s[1];
  wire cs_rise = ~cs_d & cs_s[1];
  // ==========================================================
  // SCK mode: external after reset release (synchroniser still low), sampled at each chip-select fall
  reg int_sck;
  reg mode_pending;
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      int_sck <= 1'b1;
      mode_pending <= 1'b1;
    end
    else if (mode_pending || cs_fall)
    begin
      int_sck <= sck_s[1];
      mode_pending <= 1'b0;
    end
  end
  // Internal SCK divider runs only in sleep and data states with chip select low
  localparam ST_CONV = 3'b001;
  localparam ST_SLEEP = 3'b010;
  localparam ST_DATA = 3'b100;
  reg [2:0] state;
  reg [3:0] div_cnt;
  wire int_run = int_sck & cs_low & (state != ST_CONV);
  always @(posedge clk_in)
  begin
    if (!rst_n_in || !int_run)
    begin
      div_cnt <= 4'h0;
      sck_out <= 1'b0;
    end
    else if (div_cnt == `ASRF_SCK_HALF - 1)
    begin
      div_cnt <= 4'h0;
      sck_out <= ~sck_out;
    end
    else
    begin
      div_cnt <= div_cnt + 4'h1;
    end
  end
  assign sck_oe_out = int_sck & cs_low;
  // Edges come from the driven clock or the sampled pin; ignored with chip select high
  reg sck_out_d;
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      sck_out_d <= 1'b0;
    end
    else
    begin
      sck_out_d <= sck_out;
    end
  end
  wire sck_rise = cs_low & (int_sck ? (sck_out & ~sck_out_d) : (sck_s[1] & ~sck_d));
  wire sck_fall = cs_low & (int_sck ? (~sck_out & sck_out_d) : (~sck_s[1] & sck_d));
  // ==========================================================
  // Result FIFO, fed by the core and drained one frame per conversion
  wire fifo_valid;
  wire [`ASRF_IN_BITS-1:0] fifo_data;
  reg fifo_take;
  asrf_fifo #(
    .WIDTH(`ASRF_IN_BITS),
    .DEPTH(FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(result_valid_in),
    .in_data_in(result_in),
    .in_ready_out(result_ready_out),
    .out_valid_out(fifo_valid),
    .out_data_out(fifo_data),
    .out_ready_in(fifo_take)
  );
  // ==========================================================
  // Frame formatting
  reg [`ASRF_RES_BITS:0] coded;
  reg [`ASRF_FRAME_BITS-1:0] next_frame;
  always @*
  begin
    if ($signed(fifo_data) > $signed(`ASRF_FS_POS))
    begin
      coded = {1'b1, 1'b1, 22'h000000};
    end
    else if ($signed(fifo_data) < $signed(`ASRF_FS_NEG))
    begin
      coded = {1'b0, 1'b0, 22'h3FFFFF};
    end
    else
    begin
      // Offset coding: sign high for zero and up; -1 is 0/all ones, -FS is 0,1,0...
      coded = fifo_data[23:0] ^ 24'h800000;
      coded[23] = ~fifo_data[23];
    end
    next_frame = {1'b0, 1'b0, coded, conv_addr_out, 1'b0};
    next_frame[`ASRF_BIT_PARITY] = ^next_frame[31:1];
  end
  // ==========================================================
  // Conversion, sleep and data states
  reg [`ASRF_FRAME_BITS-1:0] shreg;
  reg [5:0] bit_cnt;
  reg [`ASRF_ADDR_BITS-1:0] addr_sh;
  reg [2:0] addr_cnt;
  reg [`ASRF_ADDR_BITS-1:0] next_addr;
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      state <= ST_CONV;
      converting_out <= 1'b1;
      conv_start_out <= 1'b1;
      conv_addr_out <= `ASRF_ADDR_RESET;
      next_addr <= `ASRF_ADDR_RESET;
      shreg <= 32'hFFFFFFFF;
      bit_cnt <= 6'h00;
      addr_sh <= 5'h00;
      addr_cnt <= 3'h0;
      fifo_take <= 1'b0;
      sdo_out <= 1'b1;
    end
    else
    begin
      conv_start_out <= 1'b0;
      fifo_take <= 1'b0;
      case (state)
        ST_CONV:
        begin
          sdo_out <= 1'b1;
          if (fifo_valid && !fifo_take)
          begin
            shreg <= next_frame;
            fifo_take <= 1'b1;
            converting_out <= 1'b0;
            sdo_out <= 1'b0;
            state <= ST_SLEEP;
          end
        end
        ST_SLEEP:
        begin
          sdo_out <= shreg[`ASRF_BIT_DONE];
          if (sck_rise)
          begin
            state <= ST_DATA;
            bit_cnt <= 6'h00;
            addr_sh <= {addr_sh[3:0], sdi_s[1]};
            addr_cnt <= 3'h1;
          end
        end
        ST_DATA:
        begin
          if (cs_rise)
          begin
            // Abort keeps old address unless all five bits arrived
            conv_addr_out <= next_addr;
            converting_out <= 1'b1;
            conv_start_out <= 1'b1;
            state <= ST_CONV;
          end
          else
          begin
            if (sck_rise && addr_cnt < `ASRF_ADDR_BITS)
            begin
              addr_sh <= {addr_sh[3:0], sdi_s[1]};
              addr_cnt <= addr_cnt + 3'h1;
              if (addr_cnt == `ASRF_ADDR_BITS - 1)
              begin
                next_addr <= {addr_sh[3:0], sdi_s[1]};
              end
            end
            if (sck_fall)
            begin
              bit_cnt <= bit_cnt + 6'h01;
              if (bit_cnt == `ASRF_FRAME_BITS - 1)
              begin
                sdo_out <= 1'b1;
                conv_addr_out <= next_addr;
                converting_out <= 1'b1;
                conv_start_out <= 1'b1;
                state <= ST_CONV;
              end
              else
              begin
                shreg <= {shreg[30:0], 1'b0};
                sdo_out <= shreg[30];
              end
            end
          end
        end
        default:
        begin
          state <= ST_CONV;
        end
      endcase
    end
  end
  assign sdo_oe_out = cs_low;
  // ==========================================================
  // Conversion clock source: toggles within the timeout mean an external clock
  reg [19:0] fo_timer;
  reg [1:0] fo_edges;
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      fo_timer <= 20'h00000;
      fo_edges <= 2'h0;
      ext_clock_mode_out <= 1'b0;
      osc_enable_out <= 1'b1;
      reject_50hz_out <= 1'b0;
    end
    else
    begin
      if (fo_s[1] != fo_d)
      begin
        fo_timer <= 20'h00000;
        if (fo_edges == 2'h2)
        begin
          ext_clock_mode_out <= 1'b1;
          osc_enable_out <= 1'b0;
        end
        else
        begin
          fo_edges <= fo_edges + 2'h1;
        end
      end
      else if (fo_timer >= EXT_TIMEOUT[19:0])
      begin
        fo_edges <= 2'h0;
        ext_clock_mode_out <= 1'b0;
        osc_enable_out <= 1'b1;
        // Only a steady level selects the notch; serial path is untouched
        reject_50hz_out <= fo_s[1];
      end
      else
      begin
        fo_timer <= fo_timer + 20'h00001;
      end
    end
  end
endmodule // asrf_framer

// ### hw/asrf_map.vh
/*
  Constants for the serial result framer: frame layout, coding limits and timing counts.
  Assumes a 20 MHz system clock; included by the framer and its monitor.
*/
`ifndef ASRF_MAP_VH
`define ASRF_MAP_VH
// ==========================================================
// Frame layout
`define ASRF_FRAME_BITS 32
`define ASRF_BIT_DONE 31
`define ASRF_BIT_FILLER 30
`define ASRF_BIT_SIGN 29
`define ASRF_BIT_RES_MSB 28
`define ASRF_BIT_RES_LSB 6
`define ASRF_BIT_ADDR_MSB 5
`define ASRF_BIT_ADDR_LSB 1
`define ASRF_BIT_PARITY 0
`define ASRF_RES_BITS 23
`define ASRF_ADDR_BITS 5
// ==========================================================
// Result coding: 24-bit two's complement input, limits are +FS and -FS
`define ASRF_IN_BITS 24
`define ASRF_FS_POS 24'h400000
`define ASRF_FS_NEG 24'hC00000
`define ASRF_ADDR_RESET 5'h00
// ==========================================================
// Timing
`define ASRF_CLK_HZ 20000000
// Lowest detectable external conversion clock
`define ASRF_EXT_MIN_HZ 2560
// Longest half period of that clock, in system cycles (rounded down)
`define ASRF_EXT_TIMEOUT (`ASRF_CLK_HZ / (2 * `ASRF_EXT_MIN_HZ))
// Internal SCK divider: half period in system cycles
`define ASRF_SCK_HALF 8
`endif

// ### verification/asrf_framer_monitor.sv
/*
  Port checker for asrf_framer, bound to every instance.
  Assumes external pins are synced inside the framer in two or three cycles.
*/
`timescale 1ns/1ns
`include "asrf_map.vh"
module asrf_framer_monitor #(
  parameter FIFO_DEPTH = 8,
  parameter EXT_TIMEOUT = 50
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // Core side
  input wire result_valid_in,
  input wire [`ASRF_IN_BITS-1:0] result_in,
  input wire result_ready_out,
  input wire conv_start_out,
  input wire [`ASRF_ADDR_BITS-1:0] conv_addr_out,
  input wire converting_out,
  // Clock source
  input wire rejection_clock_select_in,
  input wire ext_clock_mode_out,
  input wire osc_enable_out,
  input wire reject_50hz_out,
  // Serial pins
  input wire cs_n_in,
  input wire sck_in,
  input wire sck_out,
  input wire sck_oe_out,
  input wire sdi_in,
  input wire sdo_out,
  input wire sdo_oe_out
);
  // ==========
  // Properties
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sdo_released_a: assert property (cs_n_in [*3] |-> !sdo_oe_out)
    else $error("sdo driven while deselected");
  sck_drive_a: assert property (sck_oe_out |-> sdo_oe_out)
    else $error("sck driven while deselected");
  start_conv_a: assert property (conv_start_out |-> converting_out && (sdo_out || !sdo_oe_out))
    else $error("start without conversion");
  done_high_a: assert property (converting_out && $past(converting_out) && sdo_oe_out |-> sdo_out)
    else $error("done flag low while converting");
  done_fall_a: assert property ($fell(converting_out) && sdo_oe_out |-> ##[0:1] !sdo_out)
    else $error("done flag late");
  clock_src_a: assert property (osc_enable_out == !ext_clock_mode_out)
    else $error("oscillator and external mode disagree");
  notch_pin_a: assert property ($changed(reject_50hz_out) && !ext_clock_mode_out
    |-> reject_50hz_out == $past(rejection_clock_select_in, 3))
    else $error("notch differs from pin");
  sdo_hold_a: assert property (sck_in [*3] ##0 !sck_oe_out && !$fell(converting_out)
    |-> $stable(sdo_out))
    else $error("sdo moved with sck high");
  addr_update_a: assert property ($changed(conv_addr_out)
    |-> conv_start_out || $past(conv_start_out))
    else $error("address moved outside start");
endmodule // asrf_framer_monitor
bind asrf_framer asrf_framer_monitor #(.FIFO_DEPTH(FIFO_DEPTH), .EXT_TIMEOUT(EXT_TIMEOUT)) u_mon (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .result_valid_in(result_valid_in),
  .result_in(result_in), .result_ready_out(result_ready_out), .conv_start_out(conv_start_out),
  .conv_addr_out(conv_addr_out), .converting_out(converting_out),
  .rejection_clock_select_in(rejection_clock_select_in), .ext_clock_mode_out(ext_clock_mode_out),
  .osc_enable_out(osc_enable_out), .reject_50hz_out(reject_50hz_out), .cs_n_in(cs_n_in),
  .sck_in(sck_in), .sck_out(sck_out), .sck_oe_out(sck_oe_out), .sdi_in(sdi_in),
  .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out));

// ### verification/asrf_host.sv
/*
  Host SPI master model: chip select, serial clock and address bits out, frame in.
  Assumes external serial clock mode unless the clock line is parked high at select.
*/
`timescale 1ns/1ns
module asrf_host (
  // Clock
  input wire clk_in,
  // Serial lines
  output logic cs_n_out,
  output logic sck_out,
  output logic sdi_out,
  input wire sdo_in
);
  // ==========
  // Tasks
  initial
  begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    sdi_out = 1'b0;
  end
  task automatic sel(input logic v);
    @(posedge clk_in);
    cs_n_out <= v;
    repeat (4) @(posedge clk_in);
  endtask
  // Parks the clock line; high at a select edge asks for the device's own clock
  task automatic park(input logic v);
    @(posedge clk_in);
    sck_out <= v;
    sdi_out <= 1'b0;
  endtask
  // Half period of 4 clocks keeps the 400 ns serial period
  task automatic xfer(input int n, input logic [4:0] a, output logic [31:0] f);
    int i;
    f = 32'h0;
    @(posedge clk_in);
    sdi_out <= a[4];
    repeat (4) @(posedge clk_in);
    for (i = 0; i < n; i++)
    begin
      sck_out <= 1'b1;
      f = {f[30:0], sdo_in};
      repeat (4) @(posedge clk_in);
      sck_out <= 1'b0;
      sdi_out <= (i < 4) ? a[3 - i] : ~sdi_out;
      repeat (4) @(posedge clk_in);
    end
  endtask
endmodule // asrf_host

// ### verification/tb.sv
/*
  Bench for asrf_framer: results in, frames read through the host model.
  Assumes sck held low at reset, which picks external serial clock.
*/
`timescale 1ns/1ns
module tb;
  localparam int FD = 8;
  localparam int TMO = 50;
  logic clk_in, rst_n_in, result_valid_in, rcs, last_sdo, ok, sck_prv;
  logic [23:0] result_in;
  logic [31:0] f;
  logic [4:0] pa;
  logic [23:0] tbl [9];
  wire rdy, cst, conv, ext, osc, n50, sdo, sdo_oe, sck_oe, cs_n, sck, sdi, sdo_w, sck_dev;
  wire [4:0] addr;
  int n_fail, num_checks, i, cnt;
  // ==========
  // Design and host
  asrf_framer #(.FIFO_DEPTH(FD), .EXT_TIMEOUT(TMO)) u_asrf_framer (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .result_valid_in(result_valid_in),
    .result_in(result_in), .result_ready_out(rdy), .conv_start_out(cst),
    .conv_addr_out(addr), .converting_out(conv), .rejection_clock_select_in(rcs),
    .ext_clock_mode_out(ext), .osc_enable_out(osc), .reject_50hz_out(n50),
    .cs_n_in(cs_n), .sck_in(sck), .sck_out(sck_dev), .sck_oe_out(sck_oe), .sdi_in(sdi),
    .sdo_out(sdo), .sdo_oe_out(sdo_oe));
  asrf_host u_asrf_host (.clk_in(clk_in), .cs_n_out(cs_n), .sck_out(sck), .sdi_out(sdi),
    .sdo_in(sdo_w));
  // Released line shows a changing pattern, held high only during reset
  assign sdo_w = sdo_oe ? sdo : ~last_sdo;
  always @(posedge clk_in) last_sdo <= rst_n_in ? sdo_w : 1'b0;
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // ==========
  // Tasks
  task automatic end_sim();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] mk(input logic [23:0] v, input logic [4:0] a);
    logic [23:0] c;
    logic [31:0] r;
    c = v;
    if (!v[23] && v >= 24'h400000) c = 24'h400000;
    if (v[23] && v < 24'hC00000) c = 24'hBFFFFF;
    r = {2'b00, ~c[23], c[22:0], a, 1'b0};
    r[0] = ^r[31:1];
    return r;
  endfunction
  task automatic push(input logic [23:0] v, input int lim, output logic k_ok);
    int k;
    k_ok = 1'b0;
    @(posedge clk_in);
    result_in <= v;
    result_valid_in <= 1'b1;
    for (k = 0; k < lim && !k_ok; k++)
    begin
      @(posedge clk_in);
      k_ok = (rdy === 1'b1);
    end
    result_valid_in <= 1'b0;
  endtask
  task automatic rd(input int n, input logic [23:0] v, input logic [4:0] a);
    u_asrf_host.sel(1'b1);
    push(v, 20, ok);
    u_asrf_host.sel(1'b0);
    for (i = 0; i < 300 && sdo_w !== 1'b0; i++) @(posedge clk_in);
    if (sdo_w !== 1'b0)
    begin
      chk("eoc wait", 0, sdo_w);
      end_sim();
    end
    u_asrf_host.xfer(n, a, f);
  endtask
  // ==========
  // Sequence
  initial
  begin
    rst_n_in = 1'b0;
    result_valid_in = 1'b0;
    result_in = 24'h000000;
    rcs = 1'b0;
    n_fail = 0;
    num_checks = 0;
    tbl = '{24'h000000, 24'hFFFFFF, 24'h400000, 24'h7FFFFF, 24'hC00000, 24'h800000,
      24'h3FFFFF, 24'h000001, 24'h200000};
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk("sdo_oe", 0, sdo_oe);
    u_asrf_host.xfer(4, 5'h1F, f);
    u_asrf_host.sel(1'b0);
    chk("busy flag", 1, sdo_w);
    chk("sck_oe", 0, sck_oe);
    rd(32, 24'h123456, 5'h13);
    chk("frame", mk(24'h123456, 5'h00), f);
    repeat (2) @(posedge clk_in);
    chk("new flag", 1, sdo_w);
    chk("converting", 1, conv);
    chk("addr", 5'h13, addr);
    rd(3, 24'hF00001, 5'h0A);
    chk("partial", mk(24'hF00001, 5'h13) >> 29, f);
    rd(32, 24'h0ABCDE, 5'h05);
    chk("kept addr", mk(24'h0ABCDE, 5'h13), f);
    u_asrf_host.sel(1'b1);
    cnt = 0;
    for (i = 0; i < 10; i++)
    begin
      push(tbl[i % 9], 3, ok);
      cnt += ok;
    end
    chk("fifo fill", FD + 1, cnt);
    pa = 5'h05;
    for (cnt = 0; cnt < 9; cnt++)
    begin
      u_asrf_host.sel(1'b0);
      repeat (4) @(posedge clk_in);
      u_asrf_host.xfer(32, {1'b1, cnt[3:0]}, f);
      chk("drain", mk(tbl[cnt], pa), f);
      pa = {1'b1, cnt[3:0]};
      u_asrf_host.sel(1'b1);
    end
    // Internal serial clock: the device makes sck, the bench reads on its rises
    u_asrf_host.park(1'b1);
    push(24'h654321, 20, ok);
    u_asrf_host.sel(1'b0);
    repeat (2) @(posedge clk_in);
    chk("sck_oe int", 1, sck_oe);
    f = 32'h0;
    cnt = 0;
    sck_prv = 1'b0;
    for (i = 0; i < 2000 && cnt < 32; i++)
    begin
      @(negedge clk_in);
      if (sck_dev && !sck_prv)
      begin
        f = {f[30:0], sdo_w};
        cnt++;
      end
      sck_prv = sck_dev;
    end
    if (cnt != 32)
    begin
      chk("int bits", 32, cnt);
      end_sim();
    end
    chk("int frame", mk(24'h654321, pa), f);
    repeat (12) @(posedge clk_in);
    chk("int flag", 1, sdo_w);
    chk("int sck idle", 0, sck_dev);
    chk("int addr", 0, addr);
    u_asrf_host.sel(1'b1);
    u_asrf_host.park(1'b0);
    rcs <= 1'b1;
    repeat (3 * TMO) @(posedge clk_in);
    chk("notch 50", 1, n50);
    chk("osc on", 1, osc);
    for (i = 0; i < 12; i++)
    begin
      repeat (TMO / 2) @(posedge clk_in);
      rcs <= ~rcs;
    end
    @(posedge clk_in);
    chk("ext mode", 1, ext);
    chk("osc off", 0, osc);
    rcs <= 1'b0;
    repeat (3 * TMO) @(posedge clk_in);
    chk("ext gone", 0, ext);
    chk("notch 60", 0, n50);
    end_sim();
  end
endmodule // tb
